// File: hdl/cpu_pkg.sv
// Constants, opcodes and types for the test, transfer and addressing block
//
// Function
// RULE1: The test operation subtracts zero from A, X or a memory byte, sets N and Z, clears V and keeps H, I and C.
// RULE2: Test opcodes are 3D direct, 4D on A, 5D on X, 6D byte-offset indexed, 7D plain indexed and 9E6D stack byte-offset, taking 3, 1, 1, 3, 2 and 4 cycles.
// RULE3: Full-address mode fetches two operand bytes, high then low, and uses them as the 16-bit address.
// RULE4: Word-offset indexed mode fetches a two-byte offset, high first, and adds it to H:X.
// RULE5: Byte-offset indexed mode fetches one unsigned offset byte and adds it to H:X.
// RULE6: Post-increment indexed mode accesses memory at H:X and then adds one to H:X.
// RULE7: Stack offset modes add a one-byte or two-byte offset to SP to form the address.
// RULE8: The direct-to-direct move reads a byte at one direct address and writes it to a second one.
// RULE9: The indexed-to-direct move reads at H:X, increments H:X and stores the byte at a direct address.
// RULE10: The direct-to-indexed move reads at a direct address, stores at H:X and then increments H:X.
// RULE11: Byte 9E is a prefix that picks the stack-offset form of the following opcode.
// RULE12: Opcode 95 loads H:X with SP plus one in 2 cycles, 94 loads SP with H:X minus one in 2 cycles, 9F copies X to A in 1 cycle, none touching flags.
package cpu_pkg;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_PREFIX = 8'h9e;
	localparam logic [7:0] OP_TEST_DIR = 8'h3d;
	localparam logic [7:0] OP_TEST_ACC = 8'h4d;
	localparam logic [7:0] OP_TEST_XLO = 8'h5d;
	localparam logic [7:0] OP_TEST_XBYTE = 8'h6d;
	localparam logic [7:0] OP_TEST_XPLAIN = 8'h7d;
	localparam logic [7:0] OP_SP_TO_HX = 8'h95;
	localparam logic [7:0] OP_HX_TO_SP = 8'h94;
	localparam logic [7:0] OP_X_TO_A = 8'h9f;
	localparam logic [7:0] OP_MOVE_D2D = 8'h4e;
	localparam logic [7:0] OP_MOVE_D2X = 8'h5e;
	localparam logic [7:0] OP_MOVE_X2D = 8'h7e;

	// ------------------------------------------------------------
	// Flag positions, reset values, zero page and test subtrahend
	// ------------------------------------------------------------
	localparam int FLAG_V = 7;
	localparam int FLAG_H = 4;
	localparam int FLAG_I = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;
	localparam logic [7:0] FLAGS_RST = 8'h68;
	localparam logic [15:0] SP_RST = 16'h00ff;
	localparam logic [15:0] HX_RST = 16'h0000;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] ZERO_PAGE = 8'h00;
	localparam logic [7:0] TEST_SUBTRAHEND = 8'h00;

	// ------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------
	localparam logic [2:0] CYC_TEST_DIR = 3'h3;
	localparam logic [2:0] CYC_TEST_REG = 3'h1;
	localparam logic [2:0] CYC_TEST_XBYTE = 3'h3;
	localparam logic [2:0] CYC_TEST_XPLAIN = 3'h2;
	localparam logic [2:0] CYC_TEST_SBYTE = 3'h4;
	localparam logic [2:0] CYC_XFER_STK = 3'h2;
	localparam logic [2:0] CYC_X_TO_A = 3'h1;
	localparam logic [2:0] CYC_MOVE_D2D = 3'h5;
	localparam logic [2:0] CYC_MOVE_XINC = 3'h4;
	localparam logic [2:0] CYC_EA_NONE = 3'h1;
	localparam logic [2:0] CYC_EA_BYTE = 3'h2;
	localparam logic [2:0] CYC_EA_WORD = 3'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		implied_operand_mode = 4'h0,
		direct_mode = 4'h1,
		full_address_mode = 4'h2,
		index_plain_mode = 4'h3,
		index_byte_offset_mode = 4'h4,
		index_word_offset_mode = 4'h5,
		index_postinc_mode = 4'h6,
		stack_byte_offset_mode = 4'h7,
		stack_word_offset_mode = 4'h8
	} ea_mode_t;

	typedef enum logic [3:0] {
		k_none = 4'h0,
		k_test_mem = 4'h1,
		k_test_acc = 4'h2,
		k_test_xlo = 4'h3,
		stackptr_to_index_op = 4'h4,
		index_to_stackptr_op = 4'h5,
		indexlow_to_acc_op = 4'h6,
		mem_to_mem_direct_mode = 4'h7,
		direct_to_index_postinc_mode = 4'h8,
		index_postinc_to_direct_mode = 4'h9,
		k_addr_only = 4'ha
	} op_kind_t;

	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_prefix = 3'b001,
		st_fetch1 = 3'b011,
		st_fetch2 = 3'b010,
		st_read = 3'b110,
		st_write = 3'b111,
		st_finish = 3'b101,
		st_pad = 3'b100
	} seq_state_t;

endpackage : cpu_pkg

// File: hdl/ea_adder.sv
// Effective address former for all addressing modes
`timescale 1ns/1ps
module ea_adder
	import cpu_pkg::*;
#(
	parameter int AW = 16
) (
	input wire ea_mode_t mode,
	input wire logic [AW-1:0] hx,
	input wire logic [AW-1:0] sp,
	input wire logic [7:0] hi,
	input wire logic [7:0] lo,
	output logic [AW-1:0] ea
);

	logic [AW-1:0] word_off;
	logic [AW-1:0] byte_off;

	assign word_off = AW'({hi, lo});
	assign byte_off = AW'(lo);

	always_comb begin
		unique case (mode)
			implied_operand_mode: ea = hx;
			direct_mode: ea = AW'({ZERO_PAGE, lo});
			full_address_mode: ea = word_off; // see RULE3
			index_plain_mode: ea = hx;
			index_postinc_mode: ea = hx; // see RULE6
			index_byte_offset_mode: ea = hx + byte_off; // see RULE5
			index_word_offset_mode: ea = hx + word_off; // see RULE4
			stack_byte_offset_mode: ea = sp + byte_off; // see RULE7
			stack_word_offset_mode: ea = sp + word_off; // see RULE7
			default: ea = hx;
		endcase
	end

endmodule : ea_adder

// File: hdl/cpu_test_transfer_addressing.sv
// Sequencer for test, stack/index transfer, move and address-forming operations
`timescale 1ns/1ps
module cpu_test_transfer_addressing
	import cpu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic prefix,
	input wire logic [7:0] opcode,
	input wire logic ea_req,
	input wire ea_mode_t ea_mode_in,
	output logic ready,
	output logic done,
	output logic bad_op,
	output logic [15:0] ea_out,
	input wire logic ld_en,
	input wire logic [7:0] ld_acc,
	input wire logic [15:0] ld_hx,
	input wire logic [15:0] ld_sp,
	input wire logic [15:0] ld_pc,
	input wire logic [7:0] ld_flags,
	output logic [7:0] acc,
	output logic [15:0] hx,
	output logic [15:0] sp,
	output logic [15:0] pc,
	output logic [7:0] flags,
	output logic mem_rd,
	output logic mem_wr,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	seq_state_t st_reg, st_next;
	op_kind_t kind_reg, kind_next;
	ea_mode_t mode_reg, mode_next;
	logic [7:0] acc_reg, acc_next;
	logic [15:0] hx_reg, hx_next;
	logic [15:0] sp_reg, sp_next;
	logic [15:0] pc_reg, pc_next;
	logic [7:0] condition_flags_reg, condition_flags_next;
	logic [7:0] hi_reg, hi_next;
	logic [7:0] dst_reg, dst_next;
	logic [7:0] mdata_reg, mdata_next;
	logic [15:0] ea_reg, ea_next;
	logic bad_reg, bad_next;
	logic [2:0] exp_reg, exp_next;
	logic [2:0] cyc_reg, cyc_next;
	logic [15:0] ea_comb;
	logic [7:0] test_val;
	logic two_byte;

	ea_adder #(.AW(16)) u_ea (
		.mode(mode_reg),
		.hx(hx_reg),
		.sp(sp_reg),
		.hi(hi_reg),
		.lo(mem_rdata),
		.ea(ea_comb)
	);

	assign two_byte = (mode_reg == full_address_mode) || (mode_reg == index_word_offset_mode)
		|| (mode_reg == stack_word_offset_mode);
	assign ready = (st_reg == st_idle);
	assign done = (st_reg == st_finish);
	assign bad_op = bad_reg;
	assign ea_out = ea_reg;
	assign acc = acc_reg;
	assign hx = hx_reg;
	assign sp = sp_reg;
	assign pc = pc_reg;
	assign flags = condition_flags_reg;

	always_comb begin
		unique case (kind_reg)
			k_test_acc: test_val = acc_reg;
			k_test_xlo: test_val = hx_reg[7:0];
			k_test_mem: test_val = mem_rdata;
			default: test_val = mdata_reg;
		endcase
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		kind_next = kind_reg;
		mode_next = mode_reg;
		acc_next = acc_reg;
		hx_next = hx_reg;
		sp_next = sp_reg;
		pc_next = pc_reg;
		condition_flags_next = condition_flags_reg;
		hi_next = hi_reg;
		dst_next = dst_reg;
		mdata_next = mdata_reg;
		ea_next = ea_reg;
		bad_next = bad_reg;
		exp_next = exp_reg;
		cyc_next = (st_reg == st_idle) ? 3'h0 : cyc_reg + 3'h1;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		mem_addr = pc_reg;
		mem_wdata = mem_rdata;
		unique case (st_reg)
			st_idle: begin
				if (ld_en) begin
					acc_next = ld_acc;
					hx_next = ld_hx;
					sp_next = ld_sp;
					pc_next = ld_pc;
					condition_flags_next = ld_flags;
				end else if (ea_req) begin
					// Address-only service for other instruction groups
					kind_next = k_addr_only;
					mode_next = ea_mode_in;
					bad_next = 1'b0;
					unique case (ea_mode_in)
						implied_operand_mode, index_plain_mode, index_postinc_mode: begin
							st_next = st_finish;
							exp_next = CYC_EA_NONE;
						end
						full_address_mode, index_word_offset_mode, stack_word_offset_mode: begin
							st_next = st_fetch1;
							exp_next = CYC_EA_WORD;
						end
						default: begin
							st_next = st_fetch1;
							exp_next = CYC_EA_BYTE;
						end
					endcase
				end else if (start) begin
					bad_next = 1'b0;
					mode_next = implied_operand_mode;
					unique case ({prefix, opcode}) // see RULE2 see RULE11
						{1'b0, OP_TEST_DIR}: begin
							kind_next = k_test_mem;
							mode_next = direct_mode;
							st_next = st_fetch1;
							exp_next = CYC_TEST_DIR;
						end
						{1'b0, OP_TEST_ACC}: begin
							kind_next = k_test_acc;
							st_next = st_finish;
							exp_next = CYC_TEST_REG;
						end
						{1'b0, OP_TEST_XLO}: begin
							kind_next = k_test_xlo;
							st_next = st_finish;
							exp_next = CYC_TEST_REG;
						end
						{1'b0, OP_TEST_XBYTE}: begin
							kind_next = k_test_mem;
							mode_next = index_byte_offset_mode;
							st_next = st_fetch1;
							exp_next = CYC_TEST_XBYTE;
						end
						{1'b0, OP_TEST_XPLAIN}: begin
							kind_next = k_test_mem;
							mode_next = index_plain_mode;
							st_next = st_read;
							exp_next = CYC_TEST_XPLAIN;
						end
						{1'b1, OP_TEST_XBYTE}: begin
							// Prefix cycle is spent here, then the byte offset comes in
							kind_next = k_test_mem;
							mode_next = stack_byte_offset_mode;
							st_next = st_prefix;
							exp_next = CYC_TEST_SBYTE;
						end
						{1'b0, OP_SP_TO_HX}: begin
							kind_next = stackptr_to_index_op;
							st_next = st_pad;
							exp_next = CYC_XFER_STK;
						end
						{1'b0, OP_HX_TO_SP}: begin
							kind_next = index_to_stackptr_op;
							st_next = st_pad;
							exp_next = CYC_XFER_STK;
						end
						{1'b0, OP_X_TO_A}: begin
							kind_next = indexlow_to_acc_op;
							st_next = st_finish;
							exp_next = CYC_X_TO_A;
						end
						{1'b0, OP_MOVE_D2D}: begin
							kind_next = mem_to_mem_direct_mode;
							st_next = st_fetch1;
							exp_next = CYC_MOVE_D2D;
						end
						{1'b0, OP_MOVE_D2X}: begin
							kind_next = direct_to_index_postinc_mode;
							st_next = st_fetch1;
							exp_next = CYC_MOVE_XINC;
						end
						{1'b0, OP_MOVE_X2D}: begin
							kind_next = index_postinc_to_direct_mode;
							st_next = st_fetch1;
							exp_next = CYC_MOVE_XINC;
						end
						default: begin
							// Unknown codes finish in one cycle; their only side effect is raising bad_op
							kind_next = k_none;
							bad_next = 1'b1;
							st_next = st_finish;
							exp_next = CYC_X_TO_A;
						end
					endcase
				end
			end
			st_prefix: st_next = st_fetch1;
			st_pad: st_next = st_finish;
			st_fetch1: begin
				mem_rd = 1'b1;
				pc_next = pc_reg + 16'h0001;
				if (kind_reg == mem_to_mem_direct_mode || (kind_reg == k_addr_only && two_byte))
					st_next = st_fetch2;
				else if (kind_reg == k_addr_only)
					st_next = st_finish;
				else
					st_next = st_read;
			end
			st_fetch2: begin
				mem_rd = 1'b1;
				pc_next = pc_reg + 16'h0001;
				hi_next = mem_rdata; // see RULE3 see RULE4
				st_next = (kind_reg == k_addr_only) ? st_finish : st_read;
			end
			st_read: begin
				mem_rd = 1'b1;
				st_next = (kind_reg == k_test_mem) ? st_finish : st_write;
				unique case (kind_reg)
					mem_to_mem_direct_mode: begin
						mem_addr = {ZERO_PAGE, hi_reg}; // see RULE8
						dst_next = mem_rdata;
					end
					direct_to_index_postinc_mode: mem_addr = {ZERO_PAGE, mem_rdata}; // see RULE10
					index_postinc_to_direct_mode: begin
						mem_addr = hx_reg; // see RULE9
						dst_next = mem_rdata;
						hx_next = hx_reg + 16'h0001;
					end
					default: mem_addr = ea_comb; // see RULE5 see RULE7
				endcase
			end
			st_write: begin
				mem_wr = 1'b1;
				mdata_next = mem_rdata;
				st_next = st_finish;
				if (kind_reg == direct_to_index_postinc_mode) begin
					mem_addr = hx_reg; // see RULE10
					hx_next = hx_reg + 16'h0001;
				end else begin
					mem_addr = {ZERO_PAGE, dst_reg}; // see RULE8 see RULE9
				end
			end
			st_finish: begin
				st_next = st_idle;
				unique case (kind_reg)
					k_test_mem, k_test_acc, k_test_xlo, mem_to_mem_direct_mode,
					direct_to_index_postinc_mode, index_postinc_to_direct_mode: begin
						// H, I and C are left as they are
						condition_flags_next[FLAG_V] = 1'b0; // see RULE1
						condition_flags_next[FLAG_N] = test_val[7];
						condition_flags_next[FLAG_Z] = ((test_val - TEST_SUBTRAHEND) == 8'h00);
					end
					stackptr_to_index_op: hx_next = sp_reg + 16'h0001; // see RULE12
					index_to_stackptr_op: sp_next = hx_reg - 16'h0001; // see RULE12
					indexlow_to_acc_op: acc_next = hx_reg[7:0]; // see RULE12
					k_addr_only: begin
						ea_next = ea_comb; // see RULE3 see RULE4 see RULE5 see RULE7
						if (mode_reg == index_postinc_mode)
							hx_next = hx_reg + 16'h0001; // see RULE6
					end
					default: ea_next = ea_reg;
				endcase
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= st_idle;
			kind_reg <= k_none;
			mode_reg <= implied_operand_mode;
			acc_reg <= ACC_RST;
			hx_reg <= HX_RST;
			sp_reg <= SP_RST;
			pc_reg <= PC_RST;
			condition_flags_reg <= FLAGS_RST;
			hi_reg <= 8'h00;
			dst_reg <= 8'h00;
			mdata_reg <= 8'h00;
			ea_reg <= 16'h0000;
			bad_reg <= 1'b0;
			exp_reg <= 3'h0;
			cyc_reg <= 3'h0;
		end else if (ce) begin
			st_reg <= st_next;
			kind_reg <= kind_next;
			mode_reg <= mode_next;
			acc_reg <= acc_next;
			hx_reg <= hx_next;
			sp_reg <= sp_next;
			pc_reg <= pc_next;
			condition_flags_reg <= condition_flags_next;
			hi_reg <= hi_next;
			dst_reg <= dst_next;
			mdata_reg <= mdata_next;
			ea_reg <= ea_next;
			bad_reg <= bad_next;
			exp_reg <= exp_next;
			cyc_reg <= cyc_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys iff ce); endclocking
	default disable iff (!rst_n);

	a_cycle_count: assert property (done |-> cyc_reg + 3'h1 == exp_reg) // see RULE2
		else $error("instruction length differs from table");
	a_stack_test_len: assert property (ready && start && prefix // see RULE11
		&& opcode == OP_TEST_XBYTE && !ld_en && !ea_req
		|=> st_reg == st_prefix ##1 st_reg == st_fetch1 ##2 done)
		else $error("prefixed test did not take four cycles");
	a_test_flags: assert property (done && kind_reg == k_test_mem |=> // see RULE1
		!flags[FLAG_V] && flags[FLAG_N] == $past(mem_rdata[7])
		&& flags[FLAG_Z] == ($past(mem_rdata) == 8'h00))
		else $error("test flags wrong");
	a_test_keep: assert property (done && kind_reg == k_test_acc |=> // see RULE1
		flags[FLAG_H] == $past(flags[FLAG_H]) && flags[FLAG_I] == $past(flags[FLAG_I])
		&& flags[FLAG_C] == $past(flags[FLAG_C]))
		else $error("test touched H, I or C");
	a_full_addr_order: assert property (st_reg == st_fetch2 // see RULE3
		&& kind_reg == k_addr_only && mode_reg == full_address_mode
		|=> ##1 ea_out == {$past(mem_rdata, 2), $past(mem_rdata, 1)})
		else $error("full address byte order wrong");
	a_word_off_sum: assert property (st_reg == st_fetch2 // see RULE4
		&& kind_reg == k_addr_only && mode_reg == index_word_offset_mode
		|=> ##1 ea_out == $past(hx, 2) + {$past(mem_rdata, 2), $past(mem_rdata, 1)})
		else $error("word offset sum wrong");
	a_byte_off_sum: assert property (done && kind_reg == k_addr_only // see RULE5
		&& mode_reg == index_byte_offset_mode
		|=> ea_out == $past(hx) + {8'h00, $past(mem_rdata)})
		else $error("byte offset sum wrong");
	a_stack_off_addr: assert property (st_reg == st_read && kind_reg == k_test_mem // see RULE7
		&& mode_reg == stack_byte_offset_mode
		|-> mem_rd && mem_addr == sp + {8'h00, mem_rdata})
		else $error("stack offset address wrong");
	a_postinc_hx: assert property (done && kind_reg == k_addr_only // see RULE6
		&& mode_reg == index_postinc_mode
		|=> hx == $past(hx) + 16'h0001 && ea_out == $past(hx))
		else $error("post increment wrong");
	a_direct_move: assert property (st_reg == st_write // see RULE8
		&& kind_reg == mem_to_mem_direct_mode
		|-> mem_wr && mem_addr == {8'h00, $past(mem_rdata)}
		&& $past(mem_addr) == {8'h00, $past(mem_rdata, 2)})
		else $error("direct move addresses wrong");
	a_index_read_inc: assert property (st_reg == st_read // see RULE9
		&& kind_reg == index_postinc_to_direct_mode
		|-> mem_addr == hx ##1 mem_wr && hx == $past(hx) + 16'h0001)
		else $error("indexed to direct move wrong");
	a_index_write_inc: assert property (st_reg == st_write // see RULE10
		&& kind_reg == direct_to_index_postinc_mode
		|-> mem_addr == hx ##1 hx == $past(hx) + 16'h0001)
		else $error("direct to indexed move wrong");
	a_sp_to_hx: assert property (done && kind_reg == stackptr_to_index_op // see RULE12
		|=> hx == $past(sp) + 16'h0001 && $stable(flags))
		else $error("stack to index transfer wrong");

	c_stack_test: cover property (done && kind_reg == k_test_mem
		&& mode_reg == stack_byte_offset_mode);
	c_move_direct: cover property (done && kind_reg == mem_to_mem_direct_mode);
	c_ea_full: cover property (done && kind_reg == k_addr_only && mode_reg == full_address_mode);
	c_bad_op: cover property (done && bad_op);

endmodule : cpu_test_transfer_addressing

// File: verif/cpu_test_transfer_addressing_test.sv
// Self-checking testbench for the test, transfer and addressing sequencer
`timescale 1ns/1ps
module cpu_test_transfer_addressing_test import cpu_pkg::*;;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic start = 1'b0;
	logic prefix = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic ea_req = 1'b0;
	ea_mode_t ea_mode_in = implied_operand_mode;
	logic ld_en = 1'b0;
	logic [7:0] ld_acc = 8'h00;
	logic [7:0] ld_flags = 8'h00;
	logic [15:0] ld_hx = 16'h0000;
	logic [15:0] ld_sp = 16'h0000;
	logic [15:0] ld_pc = 16'h0000;
	logic [7:0] mem_rdata = 8'h00;
	logic ready, done, bad_op, mem_rd, mem_wr;
	logic [15:0] ea_out, hx, sp, pc, mem_addr;
	logic [7:0] acc, flags, mem_wdata;
	logic [7:0] mem [0:65535];
	int bad_count = 0;
	int tests_run = 0;
	int cyc;

	cpu_test_transfer_addressing u_dut (
		.clk_sys, .rst_n, .ce, .start, .prefix, .opcode, .ea_req, .ea_mode_in,
		.ready, .done, .bad_op, .ea_out, .ld_en, .ld_acc, .ld_hx, .ld_sp, .ld_pc,
		.ld_flags, .acc, .hx, .sp, .pc, .flags, .mem_rd, .mem_wr, .mem_addr,
		.mem_wdata, .mem_rdata
	);

	always #4 clk_sys = ~clk_sys;

	// ------------------------------------------------------------
	// Synchronous memory, no wait states
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (mem_rd) begin
			mem_rdata <= mem[mem_addr];
		end
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	function automatic logic [7:0] tfl(input logic [7:0] f, input logic [7:0] v);
		return {1'b0, f[6:3], v[7], v == 8'h00, f[0]};
	endfunction : tfl

	task automatic load(input logic [7:0] a, input logic [15:0] x, input logic [15:0] s);
		ld_acc = a;
		ld_hx = x;
		ld_sp = s;
		ld_pc = 16'h0100;
		ld_flags = 8'h9d;
		ld_en = 1'b1;
		tick();
		ld_en = 1'b0;
	endtask : load

	// Issues one request; cyc ends as the cycle in which done was seen
	task automatic run(input logic pf, input logic [7:0] op, input logic ea, input ea_mode_t m);
		prefix = pf;
		opcode = op;
		ea_req = ea;
		ea_mode_in = m;
		start = ~ea;
		tick();
		start = 1'b0;
		ea_req = 1'b0;
		cyc = 1;
		while (done !== 1'b1) begin
			if (cyc > 10) begin
				bad_count++;
				$display("ERROR done expected 1 seen 0");
				conclude();
			end
			tick();
			cyc++;
		end
		tick();
	endtask : run

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [7:0] e1;
		e1 = tfl(8'h9d, 8'h00);
		load(8'h00, 16'h1280, 16'h0150);
		run(1'b0, 8'h4d, 1'b0, implied_operand_mode);
		check("test acc cycles", 16'(cyc), 16'h0001);
		check("test acc flags", {8'h00, flags}, {8'h00, e1});
		run(1'b0, 8'h5d, 1'b0, implied_operand_mode);
		check("test x cycles", 16'(cyc), 16'h0001);
		check("test x flags", {8'h00, flags}, {8'h00, tfl(e1, 8'h80)});
		check("test x keeps hx", hx, 16'h1280);
	endtask : t_regs

	task automatic t_mem(input logic pf, input logic [7:0] op, input logic [7:0] dd,
			input logic [15:0] ad, input logic [7:0] v, input int n, input logic [15:0] pce);
		mem[16'h0100] = dd;
		mem[ad] = v;
		load(8'h11, 16'h0300, 16'h0150);
		run(pf, op, 1'b0, implied_operand_mode);
		check("test mem cycles", 16'(cyc), 16'(n));
		check("test mem flags", {8'h00, flags}, {8'h00, tfl(8'h9d, v)});
		check("test mem pc", pc, pce);
		check("test mem acc", {8'h00, acc}, 16'h0011);
	endtask : t_mem

	task automatic t_xfer();
		load(8'h00, 16'h4455, 16'h01ff);
		run(1'b0, 8'h9f, 1'b0, implied_operand_mode);
		check("x to a cycles", 16'(cyc), 16'h0001);
		check("x to a", {8'h00, acc}, 16'h0055);
		run(1'b0, 8'h94, 1'b0, implied_operand_mode);
		check("hx to sp cycles", 16'(cyc), 16'h0002);
		check("hx to sp", sp, 16'h4454);
		run(1'b0, 8'h95, 1'b0, implied_operand_mode);
		check("sp to hx cycles", 16'(cyc), 16'h0002);
		check("sp to hx", hx, 16'h4455);
		check("xfer flags", {8'h00, flags}, 16'h009d);
	endtask : t_xfer

	task automatic t_mov();
		mem[16'h0100] = 8'h20;
		mem[16'h0101] = 8'h30;
		mem[16'h0020] = 8'ha5;
		load(8'h00, 16'h0500, 16'h0150);
		run(1'b0, 8'h4e, 1'b0, implied_operand_mode);
		check("move d2d cycles", 16'(cyc), 16'h0005);
		check("move d2d dest", {8'h00, mem[16'h0030]}, 16'h00a5);
		check("move d2d pc", pc, 16'h0102);
		check("move d2d flags", {8'h00, flags}, {8'h00, tfl(8'h9d, 8'ha5)});
		load(8'h00, 16'h0500, 16'h0150);
		run(1'b0, 8'h5e, 1'b0, implied_operand_mode);
		check("move d2x cycles", 16'(cyc), 16'h0004);
		check("move d2x dest", {8'h00, mem[16'h0500]}, 16'h00a5);
		check("move d2x hx", hx, 16'h0501);
		mem[16'h0100] = 8'h31;
		mem[16'h0400] = 8'h5a;
		load(8'h00, 16'h0400, 16'h0150);
		run(1'b0, 8'h7e, 1'b0, implied_operand_mode);
		check("move x2d cycles", 16'(cyc), 16'h0004);
		check("move x2d dest", {8'h00, mem[16'h0031]}, 16'h005a);
		check("move x2d hx", hx, 16'h0401);
	endtask : t_mov

	// Operand bytes 12 then 34 at pc; a swapped pair shows up in every wide mode
	task automatic t_ea();
		logic [15:0] ee [0:8];
		int ec [0:8];
		ee = '{16'h2000, 16'h0012, 16'h1234, 16'h2000, 16'h2012, 16'h3234, 16'h2000, 16'h0162,
			16'h1384};
		ec = '{1, 2, 3, 1, 2, 3, 1, 2, 3};
		mem[16'h0100] = 8'h12;
		mem[16'h0101] = 8'h34;
		for (int i = 0; i <= 8; i++) begin
			load(8'h00, 16'h2000, 16'h0150);
			run(1'b0, 8'h00, 1'b1, ea_mode_t'(i));
			check("ea cycles", 16'(cyc), 16'(ec[i]));
			check("ea value", ea_out, ee[i]);
			check("ea hx", hx, (i == 6) ? 16'h2001 : 16'h2000);
		end
	endtask : t_ea

	// Clock enable held low mid-instruction must stretch it without losing state
	task automatic t_freeze();
		mem[16'h0100] = 8'h40;
		mem[16'h0040] = 8'h80;
		load(8'h00, 16'h0300, 16'h0150);
		prefix = 1'b0;
		opcode = 8'h3d;
		start = 1'b1;
		tick();
		start = 1'b0;
		ce = 1'b0;
		repeat (3) tick();
		check("frozen pc", pc, 16'h0100);
		check("frozen done", {15'h0000, done}, 16'h0000);
		ce = 1'b1;
		repeat (3) tick();
		check("thawed flags", {8'h00, flags}, {8'h00, tfl(8'h9d, 8'h80)});
		check("thawed pc", pc, 16'h0101);
	endtask : t_freeze

	task automatic t_bad();
		run(1'b1, 8'h7d, 1'b0, implied_operand_mode);
		check("prefix misuse", {15'h0000, bad_op}, 16'h0001);
		run(1'b0, 8'h4d, 1'b0, implied_operand_mode);
		check("bad cleared", {15'h0000, bad_op}, 16'h0000);
	endtask : t_bad

	initial begin
		repeat (2) @(posedge clk_sys);
		check("reset sp", sp, 16'h00ff);
		check("reset flags", {8'h00, flags}, 16'h0068);
		check("reset ready", {15'h0000, ready}, 16'h0001);
		#1;
		rst_n = 1'b1;
		tick();
		t_regs();
		t_mem(1'b0, 8'h3d, 8'h40, 16'h0040, 8'h80, 3, 16'h0101);
		t_mem(1'b0, 8'h7d, 8'h40, 16'h0300, 8'h00, 2, 16'h0100);
		t_mem(1'b0, 8'h6d, 8'hff, 16'h03ff, 8'h7f, 3, 16'h0101);
		t_mem(1'b1, 8'h6d, 8'hff, 16'h024f, 8'h81, 4, 16'h0101);
		t_xfer();
		t_mov();
		t_ea();
		t_bad();
		t_freeze();
		conclude();
	end
endmodule : cpu_test_transfer_addressing_test
